/* verilog/dsw_pkg.sv */
// Purpose: Shared constants and types for the drive status word encoder
// Assumes: Status and command words are 16 bits wide
// Notes:   Bit positions are fixed by the drive profile
package dsw_pkg;
    // Status word bit positions
    localparam int unsigned STAT_RDY_ON    = 0;
    localparam int unsigned STAT_RDY_RUN   = 1;
    localparam int unsigned STAT_RDY_REF   = 2;
    localparam int unsigned STAT_FAULT     = 3;
    localparam int unsigned STAT_COAST_IN  = 4;
    localparam int unsigned STAT_QUICK_IN  = 5;
    localparam int unsigned STAT_INHIBIT   = 6;
    localparam int unsigned STAT_ALARM     = 7;
    localparam int unsigned STAT_AT_REF    = 8;
    localparam int unsigned STAT_REMOTE    = 9;
    localparam int unsigned STAT_SUP_HIGH  = 10;
    localparam int unsigned STAT_EXT_SITE  = 11;
    localparam int unsigned STAT_RUN_PERM  = 12;

    // Command word bit positions
    localparam int unsigned CMD_RAMP_STOP_N  = 0;
    localparam int unsigned CMD_COAST_STOP_N = 1;
    localparam int unsigned CMD_QUICK_STOP_N = 2;
    localparam int unsigned CMD_ENABLE_OP    = 3;
    localparam int unsigned CMD_FAULT_RESET  = 7;
    localparam int unsigned CMD_EXT_SITE     = 11;

    // Values after reset
    localparam logic [15:0] STAT_RESET_VALUE = 16'h0040;
    localparam logic        SUP_RESET_VALUE  = 1'b0;

    // Start-stop states
    typedef enum logic [2:0] {
        DSW_ST_INHIBIT   = 3'b000,
        DSW_ST_READY_ON  = 3'b001,
        DSW_ST_READY_RUN = 3'b010,
        DSW_ST_ENABLED   = 3'b011,
        DSW_ST_FAULT     = 3'b100
    } dsw_state_t;
endpackage : dsw_pkg

/* verilog/dsw_hyst.sv */
// Purpose: Limit supervision with hysteresis between a low and high limit
// Assumes: Unsigned values, low limit not above high limit
// Notes:   Flag is registered, one cycle behind its inputs
`timescale 1ns/100ps
module dsw_hyst #(
    parameter int unsigned W = 16
) (
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] value,
    input  wire logic [W-1:0] limit_high,
    input  wire logic [W-1:0] limit_low,
    output logic              above_flag
);
    typedef struct packed {
        logic above;
    } dsw_hyst_state_t;

    dsw_hyst_state_t s_q;
    dsw_hyst_state_t s_d;

    // Set at or above high, clear below low, else hold
    always_comb begin
        s_d = s_q;
        if (value >= limit_high) begin
            s_d.above = 1'b1;
        end else if (value < limit_low) begin
            s_d.above = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_q.above <= dsw_pkg::SUP_RESET_VALUE;
        end else begin
            s_q <= s_d;
        end
    end

    assign above_flag = s_q.above;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_hyst_set;
        (value >= limit_high) |=> above_flag;
    endproperty
    a_hyst_set: assert property (p_hyst_set) else $error("High flag not set at high limit");

    property p_hyst_clear;
        (value < limit_low && value < limit_high) |=> !above_flag;
    endproperty
    a_hyst_clear: assert property (p_hyst_clear) else $error("High flag not cleared below low limit");

    property p_hyst_hold;
        (value < limit_high && value >= limit_low) |=> (above_flag == $past(above_flag));
    endproperty
    a_hyst_hold: assert property (p_hyst_hold) else $error("High flag moved inside band");
endmodule // dsw_hyst

/* verilog/dsw_encoder.sv */
// Purpose: Builds the drive status word from the start-stop state and monitors
// Assumes: Command word and monitor inputs synchronous to clk_sys
// Notes:   Status word is registered and read only by the master
`timescale 1ns/100ps
module dsw_encoder #(
    parameter int unsigned VW = 16
) (
    input  wire logic          clk_sys,
    input  wire logic          sys_rst,
    input  wire logic [15:0]   master_command_word,
    input  wire logic          fault_event,
    input  wire logic          alarm_present,
    input  wire logic          remote_control,
    input  wire logic          external_run_permit,
    input  wire logic [VW-1:0] actual_value,
    input  wire logic [VW-1:0] reference_value,
    input  wire logic [VW-1:0] reference_tolerance,
    input  wire logic [VW-1:0] supervised_value,
    input  wire logic [VW-1:0] supervision_high,
    input  wire logic [VW-1:0] supervision_low,
    output logic [15:0]        drive_state_word
);
    typedef struct packed {
        dsw_pkg::dsw_state_t state;
        logic                reset_bit;
        logic [15:0]         word;
    } dsw_enc_state_t;

    dsw_enc_state_t s_q;
    dsw_enc_state_t s_d;
    logic           supervision_high_flag;
    logic           ramp_stop_command;
    logic           coast_stop_command;
    logic           quick_stop_command;
    logic           enable_op;
    logic           reset_rise;
    logic           reference_reached_flag;
    logic [VW-1:0]  value_diff;

    // True when the state sets the given readiness level
    function automatic logic at_least(input dsw_pkg::dsw_state_t st, input dsw_pkg::dsw_state_t lvl);
        at_least = (st != dsw_pkg::DSW_ST_FAULT) && (st >= lvl);
    endfunction

    // Stop commands are active low in the command word
    assign ramp_stop_command  = !master_command_word[dsw_pkg::CMD_RAMP_STOP_N];
    assign coast_stop_command = !master_command_word[dsw_pkg::CMD_COAST_STOP_N];
    assign quick_stop_command = !master_command_word[dsw_pkg::CMD_QUICK_STOP_N];
    assign enable_op          = master_command_word[dsw_pkg::CMD_ENABLE_OP];
    assign reset_rise         = master_command_word[dsw_pkg::CMD_FAULT_RESET] && !s_q.reset_bit;

    // Absolute difference avoids signed wrap on the tolerance test
    assign value_diff = (actual_value >= reference_value) ? (actual_value - reference_value)
                                                          : (reference_value - actual_value);
    assign reference_reached_flag = (value_diff <= reference_tolerance);

    dsw_hyst #(
        .W (VW)
    ) u_hyst (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .value      (supervised_value),
        .limit_high (supervision_high),
        .limit_low  (supervision_low),
        .above_flag (supervision_high_flag)
    );

    // Start-stop state machine and word assembly
    always_comb begin
        s_d           = s_q;
        s_d.reset_bit = master_command_word[dsw_pkg::CMD_FAULT_RESET];
        case (s_q.state)
            dsw_pkg::DSW_ST_INHIBIT: begin
                // Leaving inhibit needs ramp stop asserted, others released
                if (ramp_stop_command && !coast_stop_command && !quick_stop_command) begin
                    s_d.state = dsw_pkg::DSW_ST_READY_ON;
                end
            end
            dsw_pkg::DSW_ST_READY_ON: begin
                if (coast_stop_command || quick_stop_command) begin
                    s_d.state = dsw_pkg::DSW_ST_INHIBIT;
                end else if (!ramp_stop_command) begin
                    s_d.state = dsw_pkg::DSW_ST_READY_RUN;
                end
            end
            dsw_pkg::DSW_ST_READY_RUN: begin
                if (coast_stop_command || quick_stop_command) begin
                    s_d.state = dsw_pkg::DSW_ST_INHIBIT;
                end else if (ramp_stop_command) begin
                    s_d.state = dsw_pkg::DSW_ST_READY_ON;
                end else if (enable_op && external_run_permit) begin
                    s_d.state = dsw_pkg::DSW_ST_ENABLED;
                end
            end
            dsw_pkg::DSW_ST_ENABLED: begin
                if (coast_stop_command || quick_stop_command) begin
                    s_d.state = dsw_pkg::DSW_ST_INHIBIT;
                end else if (ramp_stop_command) begin
                    s_d.state = dsw_pkg::DSW_ST_READY_ON;
                end else if (!enable_op || !external_run_permit) begin
                    s_d.state = dsw_pkg::DSW_ST_READY_RUN;
                end
            end
            dsw_pkg::DSW_ST_FAULT: begin
                if (reset_rise) begin
                    s_d.state = dsw_pkg::DSW_ST_INHIBIT;
                end
            end
            default: begin
                s_d.state = dsw_pkg::DSW_ST_INHIBIT;
            end
        endcase
        // A new fault beats a reset edge in the same cycle
        if (fault_event) begin
            s_d.state = dsw_pkg::DSW_ST_FAULT;
        end

        // Word built from next state so it matches s_q.state
        s_d.word                        = 16'h0000;
        s_d.word[dsw_pkg::STAT_RDY_ON]    = at_least(s_d.state, dsw_pkg::DSW_ST_READY_ON);
        s_d.word[dsw_pkg::STAT_RDY_RUN]   = at_least(s_d.state, dsw_pkg::DSW_ST_READY_RUN);
        s_d.word[dsw_pkg::STAT_RDY_REF]   = at_least(s_d.state, dsw_pkg::DSW_ST_ENABLED);
        s_d.word[dsw_pkg::STAT_FAULT]     = (s_d.state == dsw_pkg::DSW_ST_FAULT);
        s_d.word[dsw_pkg::STAT_COAST_IN]  = !coast_stop_command;
        s_d.word[dsw_pkg::STAT_QUICK_IN]  = !quick_stop_command;
        s_d.word[dsw_pkg::STAT_INHIBIT]   = (s_d.state == dsw_pkg::DSW_ST_INHIBIT);
        s_d.word[dsw_pkg::STAT_ALARM]     = alarm_present;
        s_d.word[dsw_pkg::STAT_AT_REF]    = reference_reached_flag;
        s_d.word[dsw_pkg::STAT_REMOTE]    = remote_control;
        s_d.word[dsw_pkg::STAT_SUP_HIGH]  = supervision_high_flag;
        s_d.word[dsw_pkg::STAT_EXT_SITE]  = master_command_word[dsw_pkg::CMD_EXT_SITE];
        s_d.word[dsw_pkg::STAT_RUN_PERM]  = external_run_permit;
    end

    // Single register stage for all state
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_q.state     <= dsw_pkg::DSW_ST_INHIBIT;
            s_q.reset_bit <= 1'b1;
            s_q.word      <= dsw_pkg::STAT_RESET_VALUE;
        end else begin
            s_q <= s_d;
        end
    end

    // Output straight from the flop; no write path exists
    assign drive_state_word = s_q.word;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_fault_bit;
        fault_event |=> drive_state_word[dsw_pkg::STAT_FAULT] && !drive_state_word[dsw_pkg::STAT_RDY_ON];
    endproperty
    a_fault_bit: assert property (p_fault_bit) else $error("Fault not shown after fault event");

    property p_ready_order;
        drive_state_word[dsw_pkg::STAT_RDY_REF] |-> drive_state_word[dsw_pkg::STAT_RDY_RUN]
            && drive_state_word[dsw_pkg::STAT_RDY_ON] && !drive_state_word[dsw_pkg::STAT_INHIBIT];
    endproperty
    a_ready_order: assert property (p_ready_order) else $error("Enabled without lower ready bits");

    property p_coast_stop;
        coast_stop_command && !fault_event |=> drive_state_word[dsw_pkg::STAT_INHIBIT]
            || drive_state_word[dsw_pkg::STAT_FAULT];
    endproperty
    a_coast_stop: assert property (p_coast_stop) else $error("Coast stop did not inhibit");

    property p_stop_flags;
        1'b1 |=> drive_state_word[dsw_pkg::STAT_COAST_IN] == !$past(coast_stop_command)
            && drive_state_word[dsw_pkg::STAT_QUICK_IN] == !$past(quick_stop_command)
            && drive_state_word[dsw_pkg::STAT_ALARM] == $past(alarm_present);
    endproperty
    a_stop_flags: assert property (p_stop_flags) else $error("Stop or alarm flags wrong");

    property p_fault_reset;
        (drive_state_word[dsw_pkg::STAT_FAULT] && reset_rise && !fault_event)
            |=> drive_state_word[dsw_pkg::STAT_INHIBIT] && !drive_state_word[dsw_pkg::STAT_FAULT];
    endproperty
    a_fault_reset: assert property (p_fault_reset) else $error("Reset edge did not clear fault");

    property p_fault_sticky;
        (drive_state_word[dsw_pkg::STAT_FAULT] && !reset_rise) |=> drive_state_word[dsw_pkg::STAT_FAULT];
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("Fault dropped without reset edge");

    property p_site_bits;
        1'b1 |=> drive_state_word[dsw_pkg::STAT_EXT_SITE] == $past(master_command_word[dsw_pkg::CMD_EXT_SITE])
            && drive_state_word[dsw_pkg::STAT_REMOTE] == $past(remote_control)
            && drive_state_word[dsw_pkg::STAT_RUN_PERM] == $past(external_run_permit);
    endproperty
    a_site_bits: assert property (p_site_bits) else $error("Site or permit bits wrong");

    property p_at_ref;
        1'b1 |=> drive_state_word[dsw_pkg::STAT_AT_REF] == ($past(value_diff) <= $past(reference_tolerance));
    endproperty
    a_at_ref: assert property (p_at_ref) else $error("Reference reached bit wrong");

    property p_unused_zero;
        drive_state_word[15:13] == 3'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("Unused bits not zero");

    // Next-cycle form, so a one-edge reset cannot compare against a stale flag
    property p_sup_bit;
        1'b1 |=> drive_state_word[dsw_pkg::STAT_SUP_HIGH] == $past(supervision_high_flag);
    endproperty
    a_sup_bit: assert property (p_sup_bit) else $error("Supervision bit wrong");

    c_enabled:   cover property (drive_state_word[dsw_pkg::STAT_RDY_REF]);
    c_fault_rs:  cover property (drive_state_word[dsw_pkg::STAT_FAULT] ##1 drive_state_word[dsw_pkg::STAT_INHIBIT]);
    c_sup_high:  cover property (drive_state_word[dsw_pkg::STAT_SUP_HIGH]
                                 ##1 !drive_state_word[dsw_pkg::STAT_SUP_HIGH]);
    c_fault_win: cover property (fault_event && reset_rise && drive_state_word[dsw_pkg::STAT_FAULT]);
endmodule // dsw_encoder

/* dv/dsw_master_model.sv */
// Purpose: Fieldbus master station model that steers the drive by command word
// Assumes: Commands change only at rising edges of clk_sys
// Notes:   Never writes the status word; it has no port to read it either
`timescale 1ns/100ps
module dsw_master_model (
    input  wire logic        clk_sys,
    output logic      [15:0] master_command_word
);
    // Idle master sends all-zero command word
    initial master_command_word = 16'h0000;

    // One command per call, sequenced by the caller through the states
    task automatic send(input logic [15:0] v);
        @(posedge clk_sys);
        master_command_word <= v;
    endtask

    // Reset request needs a low sample before the high one, else no edge
    task automatic fault_reset(input logic [15:0] v);
        send(v & 16'hFF7F);
        send(v | 16'h0080);
    endtask
endmodule // dsw_master_model

/* dv/tb.sv */
// Purpose: Self-checking bench for the drive status word encoder
// Assumes: One-cycle status latency, two cycles for the supervision bit
// Notes:   Monitor inputs follow pending values at each rising edge
`timescale 1ns/100ps
module tb;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic [15:0] master_command_word;
    logic [15:0] drive_state_word;
    logic        fault_event = 1'b0, alarm_present = 1'b0, remote_control = 1'b0, external_run_permit = 1'b0;
    logic [15:0] actual_value = 16'h0064, reference_value = 16'h0000, reference_tolerance = 16'h0000;
    logic [15:0] supervised_value = 16'h0000, supervision_high = 16'h00C8, supervision_low = 16'h0064;
    logic        p_flt = 1'b0, p_alm = 1'b0, p_rem = 1'b0, p_prm = 1'b0;
    logic [15:0] p_act = 16'h0064, p_ref = 16'h0000, p_tol = 16'h0000, p_sup = 16'h0000;
    int          fail_count = 0;
    int          n_checks = 0;

    // 250 MHz system clock
    initial forever #2 clk_sys = ~clk_sys;

    dsw_master_model master (.clk_sys(clk_sys), .master_command_word(master_command_word));

    dsw_encoder dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .master_command_word(master_command_word),
        .fault_event(fault_event), .alarm_present(alarm_present), .remote_control(remote_control),
        .external_run_permit(external_run_permit), .actual_value(actual_value),
        .reference_value(reference_value), .reference_tolerance(reference_tolerance),
        .supervised_value(supervised_value), .supervision_high(supervision_high),
        .supervision_low(supervision_low), .drive_state_word(drive_state_word)
    );

    // Pending values land on the same edge as the next command
    always @(posedge clk_sys) begin
        fault_event         <= p_flt;
        alarm_present       <= p_alm;
        remote_control      <= p_rem;
        external_run_permit <= p_prm;
        actual_value        <= p_act;
        reference_value     <= p_ref;
        reference_tolerance <= p_tol;
        supervised_value    <= p_sup;
    end

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Command edge, then one edge of latency before the word is judged
    task automatic step(input logic [15:0] cmd, input logic [15:0] exp);
        master.send(cmd);
        @(posedge clk_sys);
        #1 check("status", drive_state_word, exp);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Start-up walk, fault entry and fault reset by rising bit 7
    task automatic t_walk;
        step(16'h0006, 16'h0031);
        step(16'h0007, 16'h0033);
        p_prm = 1'b1;
        step(16'h000F, 16'h1037);
        p_flt = 1'b1;
        step(16'h000F, 16'h1038);
        p_flt = 1'b0;
        step(16'h000F, 16'h1038);
        master.fault_reset(16'h000F);
        @(posedge clk_sys);
        #1 check("fault reset", drive_state_word, 16'h1070);
    endtask

    // Coast, quick and ramp stop, then loss of run permission
    task automatic t_stops;
        step(16'h0006, 16'h1031);
        step(16'h0007, 16'h1033);
        step(16'h000F, 16'h1037);
        step(16'h000D, 16'h1060);
        step(16'h0006, 16'h1031);
        step(16'h0007, 16'h1033);
        step(16'h000B, 16'h1050);
        step(16'h0006, 16'h1031);
        step(16'h0007, 16'h1033);
        step(16'h000F, 16'h1037);
        step(16'h000E, 16'h1031);
        step(16'h000F, 16'h1033);
        step(16'h000F, 16'h1037);
        p_prm = 1'b0;
        step(16'h000F, 16'h0033);
        step(16'h000F, 16'h0033);
    endtask

    // Alarm, remote, site echo, tolerance edges and unused bits
    task automatic t_monitors;
        p_alm = 1'b1;
        p_rem = 1'b1;
        step(16'h080F, 16'h0AB3);
        p_alm = 1'b0;
        p_rem = 1'b0;
        p_act = 16'h006E;
        p_ref = 16'h0064;
        p_tol = 16'h000A;
        step(16'h000F, 16'h0133);
        p_tol = 16'h0009;
        step(16'h000F, 16'h0033);
        p_act = 16'h005A;
        p_tol = 16'h000A;
        step(16'h000F, 16'h0133);
        p_prm = 1'b1;
        step(16'hE007, 16'h1133);
    endtask

    // Supervision bit across both limits; holds in between
    task automatic hs(input logic [15:0] v, input logic e);
        p_sup = v;
        master.send(16'h0007);
        repeat (2) @(posedge clk_sys);
        #1 check("supervision", {15'h0000, drive_state_word[10]}, {15'h0000, e});
    endtask

    task automatic t_hyst;
        hs(16'h00C7, 1'b0);
        hs(16'h00C8, 1'b1);
        hs(16'h0096, 1'b1);
        hs(16'h0064, 1'b1);
        hs(16'h0063, 1'b0);
        hs(16'h0096, 1'b0);
        hs(16'h00C9, 1'b1);
    endtask

    // Mid-run reset with bit 7 held high, then a fault racing a reset edge
    task automatic t_rerun;
        p_sup = 16'h0000;
        p_tol = 16'h0000;
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        master.send(16'h0086);
        @(posedge clk_sys);
        #1 check("mid reset", drive_state_word, 16'h0040);
        p_flt = 1'b1;
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        #1 check("fault after reset", drive_state_word, 16'h1038);
        p_flt = 1'b0;
        // Bit 7 high through reset must not count as an edge
        step(16'h0086, 16'h1038);
        master.send(16'h0006);
        #1 p_flt = 1'b1;
        master.send(16'h0086);
        #1 p_flt = 1'b0;
        @(posedge clk_sys);
        #1 check("fault beats reset edge", drive_state_word, 16'h1038);
        @(posedge clk_sys);
        #1 check("edge used once", drive_state_word, 16'h1038);
        master.fault_reset(16'h0006);
        @(posedge clk_sys);
        #1 check("fault reset again", drive_state_word, 16'h1070);
    endtask

    // Reset held, released, then reapplied mid-run
    initial begin
        repeat (16) @(posedge clk_sys);
        #1 check("reset", drive_state_word, 16'h0040);
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_walk();
        t_stops();
        t_monitors();
        t_hyst();
        t_rerun();
        print_verdict();
    end

    // Hang guard
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end
endmodule // tb
